// *** common/uife_pkg.sv ***
// Purpose: constants for the usb interrupt flag and enable block
// Assumes: 16-bit xdata addresses, 8-bit data
// Notes:   addresses of all six registers, enable reset values, common flag bit positions
package uife_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [15:0] IN_FLAGS_ADDR  = 16'h6202;
	localparam logic [15:0] OUT_FLAGS_ADDR = 16'h6204;
	localparam logic [15:0] COM_FLAGS_ADDR = 16'h6206;
	localparam logic [15:0] IN_EN_ADDR     = 16'h6207;
	localparam logic [15:0] OUT_EN_ADDR    = 16'h6209;
	localparam logic [15:0] COM_EN_ADDR    = 16'h620b;

	// ****************************************
	// widths and field positions
	// ****************************************
	localparam int EP_FLAG_W   = 6;
	localparam int COM_FLAG_W  = 4;
	localparam int FRAME_BIT   = 3;
	localparam int BUSRST_BIT  = 2;
	localparam int RESUME_BIT  = 1;
	localparam int SUSPEND_BIT = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] IN_EN_RST  = 8'h3f;
	localparam logic [7:0] OUT_EN_RST = 8'h3f;
	localparam logic [3:0] COM_EN_RST = 4'h6;
	// enables forced on by a bus reset event
	localparam logic [5:0] EP_EN_BUSRST  = 6'h3f;
	localparam logic [3:0] COM_EN_BUSRST = 4'h6;
endpackage : uife_pkg

// *** hw/uife_flag_reg.sv ***
// Purpose: group of sticky event flags cleared by a read
// Assumes: set and clear are one-cycle pulses on clk_sys_i
// Notes:   a set arriving with the clear survives it
`timescale 1ns/1ps
module uife_flag_reg #(
	parameter int WIDTH = 6
) (
	input  wire logic             clk_sys_i,
	input  wire logic             sys_rst_i,
	input  wire logic [WIDTH-1:0] set_i,
	input  wire logic             clr_i,
	output logic      [WIDTH-1:0] flag_o
);
	logic [WIDTH-1:0] flag_ff;
	logic [WIDTH-1:0] nxt_flag;

	// set is or-ed after the clear so a fresh event is never dropped
	assign nxt_flag = (flag_ff & ~{WIDTH{clr_i}}) | set_i;
	assign flag_o   = flag_ff;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flag_ff <= '0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end
endmodule : uife_flag_reg

// *** hw/uife_top.sv ***
// Purpose: usb interrupt flags, enable masks and combined cpu request
// Assumes: events are one-cycle pulses from logic on clk_sys_i
// Notes:   read data and request are registered, one cycle behind
//
// Function
// - in endpoint 1-5 flags, cleared on read
// - control endpoint flag bit 0; 7:6 zero
// - out endpoint 1-5 flags; bits 0,7:6 zero
// - frame, reset, resume, suspend flags, clear-on-read
// - in enables bits 5:0, reset to one
// - out enables 5:1; bit 0 reads one
// - common enables reset 0,1,1,0 top down
// - request only for a set and enabled flag
// - bus reset sets all but frame, suspend enables
`timescale 1ns/1ps
module uife_top
	import uife_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic [5:0]  in_ep_evt_i,
	input  wire logic [5:1]  out_ep_evt_i,
	input  wire logic [3:0]  bus_evt_i,
	output logic      [7:0]  rdata_o,
	output logic             combined_usb_cpu_irq_flag_o
);
	import uife_pkg::*;

	// ****************************************
	// address decode
	// ****************************************
	wire rd_in_flags  = rd_i && (addr_i == IN_FLAGS_ADDR);
	wire rd_out_flags = rd_i && (addr_i == OUT_FLAGS_ADDR);
	wire rd_com_flags = rd_i && (addr_i == COM_FLAGS_ADDR);
	wire wr_in_en     = wr_i && (addr_i == IN_EN_ADDR);
	wire wr_out_en    = wr_i && (addr_i == OUT_EN_ADDR);
	wire wr_com_en    = wr_i && (addr_i == COM_EN_ADDR);
	wire bus_rst_evt  = bus_evt_i[BUSRST_BIT];

	// ****************************************
	// event flags
	// ****************************************
	logic [5:0] in_endpoint_event_flags;
	logic [5:0] out_endpoint_event_flags;
	logic [3:0] common_bus_event_flags;

	uife_flag_reg #(.WIDTH(EP_FLAG_W)) u_in_flags (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.set_i     (in_ep_evt_i),
		.clr_i     (rd_in_flags),
		.flag_o    (in_endpoint_event_flags)
	);

	// bit 0 has no event source and so stays zero
	uife_flag_reg #(.WIDTH(EP_FLAG_W)) u_out_flags (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.set_i     ({out_ep_evt_i, 1'b0}),
		.clr_i     (rd_out_flags),
		.flag_o    (out_endpoint_event_flags)
	);

	uife_flag_reg #(.WIDTH(COM_FLAG_W)) u_com_flags (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.set_i     (bus_evt_i),
		.clr_i     (rd_com_flags),
		.flag_o    (common_bus_event_flags)
	);

	// ****************************************
	// enable masks
	// ****************************************
	logic [7:0] in_en_ff;
	logic [7:0] out_en_ff;
	logic [3:0] com_en_ff;
	logic [7:0] nxt_in_en;
	logic [7:0] nxt_out_en;
	logic [3:0] nxt_com_en;

	// a bus reset beats a firmware write in the same cycle; reserved 7:6 keep what was
	// written, firmware is expected to keep them zero
	assign nxt_in_en = bus_rst_evt ? {in_en_ff[7:6], EP_EN_BUSRST}
	                 : wr_in_en    ? wdata_i
	                 : in_en_ff;
	assign nxt_out_en = bus_rst_evt ? {out_en_ff[7:6], EP_EN_BUSRST}
	                  : wr_out_en   ? {wdata_i[7:1], 1'b1}
	                  : out_en_ff;
	assign nxt_com_en = bus_rst_evt ? (com_en_ff | COM_EN_BUSRST)
	                  : wr_com_en   ? wdata_i[3:0]
	                  : com_en_ff;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			in_en_ff  <= IN_EN_RST;
			out_en_ff <= OUT_EN_RST;
			com_en_ff <= COM_EN_RST;
		end else begin
			in_en_ff  <= nxt_in_en;
			out_en_ff <= nxt_out_en;
			com_en_ff <= nxt_com_en;
		end
	end

	// ****************************************
	// read data and combined request
	// ****************************************
	logic [7:0] rdata_ff;
	logic       irq_ff;
	wire  [7:0] rd_mux;
	wire        any_pending;

	// reserved bits read zero except in and out enable bits 7:6 which are plain storage and out enable bit 0 which reads one
	assign rd_mux = (addr_i == IN_FLAGS_ADDR)  ? {2'h0, in_endpoint_event_flags}
	              : (addr_i == OUT_FLAGS_ADDR) ? {2'h0, out_endpoint_event_flags}
	              : (addr_i == COM_FLAGS_ADDR) ? {4'h0, common_bus_event_flags}
	              : (addr_i == IN_EN_ADDR)     ? in_en_ff
	              : (addr_i == OUT_EN_ADDR)    ? out_en_ff
	              : (addr_i == COM_EN_ADDR)    ? {4'h0, com_en_ff}
	              : 8'h00;

	// flags always latch; only the request is gated by the enables
	assign any_pending = |(in_endpoint_event_flags & in_en_ff[5:0])
	                   | |(out_endpoint_event_flags[5:1] & out_en_ff[5:1])
	                   | |(common_bus_event_flags & com_en_ff);

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_ff <= 8'h00;
			irq_ff   <= 1'b0;
		end else begin
			rdata_ff <= rd_i ? rd_mux : rdata_ff;
			irq_ff   <= any_pending;
		end
	end

	assign rdata_o                     = rdata_ff;
	assign combined_usb_cpu_irq_flag_o = irq_ff;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	sequence in_read_quiet;
		rd_in_flags && (in_ep_evt_i == 6'h00);
	endsequence

	sequence bus_reset_seen;
		bus_rst_evt;
	endsequence

	a_in_flag_set: assert property ((|in_ep_evt_i) |=>
		((in_endpoint_event_flags & $past(in_ep_evt_i)) == $past(in_ep_evt_i)))
		else $error("in endpoint event did not set its flag");

	a_in_read_clear: assert property (in_read_quiet |=>
		(in_endpoint_event_flags == 6'h00))
		else $error("in flags not cleared by read");

	a_in_rsvd_zero: assert property (rd_in_flags |=>
		(rdata_o[7:6] == 2'h0) && (rdata_o[5:0] == $past(in_endpoint_event_flags)))
		else $error("in flag read data wrong");

	a_out_flag_read: assert property ((rd_out_flags && (out_ep_evt_i == 5'h00)) |=>
		(out_endpoint_event_flags == 6'h00) && (rdata_o[7:6] == 2'h0) && !rdata_o[0])
		else $error("out flags not cleared or reserved bits set");

	a_com_flag_read: assert property ((rd_com_flags && (bus_evt_i == 4'h0)) |=>
		(common_bus_event_flags == 4'h0) && (rdata_o[7:4] == 4'h0))
		else $error("common flags not cleared or reserved bits set");

	a_out_en_bit0: assert property ((rd_i && (addr_i == OUT_EN_ADDR)) |=> rdata_o[0])
		else $error("out enable bit 0 did not read one");

	a_busrst_enables: assert property (bus_reset_seen |=>
		(in_en_ff[5:0] == 6'h3f) && (out_en_ff[5:1] == 5'h1f) && (com_en_ff[2:1] == 2'h3)
		&& (com_en_ff[FRAME_BIT] == $past(com_en_ff[FRAME_BIT]))
		&& (com_en_ff[SUSPEND_BIT] == $past(com_en_ff[SUSPEND_BIT])))
		else $error("bus reset did not set the right enables");

	a_com_en_write: assert property ((wr_com_en && !bus_rst_evt) |=>
		(com_en_ff == $past(wdata_i[3:0])))
		else $error("common enable write not stored");

	a_irq_masked: assert property ((common_bus_event_flags[FRAME_BIT] && !com_en_ff[FRAME_BIT]
		&& (in_endpoint_event_flags == 6'h00) && (out_endpoint_event_flags == 6'h00)
		&& (common_bus_event_flags[2:0] == 3'h0)) |=> !combined_usb_cpu_irq_flag_o)
		else $error("request raised by a masked flag");

	a_irq_raised: assert property ((|(common_bus_event_flags & com_en_ff)) |=>
		combined_usb_cpu_irq_flag_o)
		else $error("enabled flag did not raise the request");

	a_set_wins: assert property ((rd_in_flags && (|in_ep_evt_i)) |=>
		(in_endpoint_event_flags == $past(in_ep_evt_i)))
		else $error("event lost during read clear");

	a_out_flag_set: assert property ((|out_ep_evt_i) |=>
		((out_endpoint_event_flags[5:1] & $past(out_ep_evt_i)) == $past(out_ep_evt_i)))
		else $error("out endpoint event did not set its flag");

	a_com_flag_set: assert property ((|bus_evt_i) |=>
		((common_bus_event_flags & $past(bus_evt_i)) == $past(bus_evt_i)))
		else $error("bus event did not set its flag");

	a_irq_idle: assert property (((in_endpoint_event_flags == 6'h00)
		&& (out_endpoint_event_flags == 6'h00) && (common_bus_event_flags == 4'h0))
		|=> !combined_usb_cpu_irq_flag_o)
		else $error("request raised with no flag set");

	a_in_en_write: assert property ((wr_in_en && !bus_rst_evt) |=>
		(in_en_ff == $past(wdata_i)))
		else $error("in enable write not stored");

	a_out_en_write: assert property ((wr_out_en && !bus_rst_evt) |=>
		(out_en_ff == {$past(wdata_i[7:1]), 1'b1}))
		else $error("out enable write not stored");
endmodule : uife_top

// *** test/tb_usb_interrupt_flags_enables.sv ***
// Purpose: self-checking bench for the usb interrupt flag block
// Assumes: event inputs are one-cycle pulses from the bench
// Notes:   expected values come from reset values and bit positions
`timescale 1ns/1ps
module tb_usb_interrupt_flags_enables;
	import uife_pkg::*;
	logic        clk;
	logic        rst;
	logic [15:0] addr;
	logic        rd;
	logic        wr;
	logic [7:0]  wdata;
	logic [5:0]  in_evt;
	logic [5:1]  out_evt;
	logic [3:0]  bus_evt;
	logic [7:0]  rdata;
	logic        irq;
	logic [7:0]  d;
	int          err_total = 0;
	int          n_checks = 0;
	uife_top uife_top_i (.clk_sys_i(clk), .sys_rst_i(rst), .addr_i(addr), .rd_i(rd),
		.wr_i(wr), .wdata_i(wdata), .in_ep_evt_i(in_evt), .out_ep_evt_i(out_evt),
		.bus_evt_i(bus_evt), .rdata_o(rdata), .combined_usb_cpu_irq_flag_o(irq));
	uife_cpu_model uife_cpu_model_i (.clk_sys_i(clk), .rdata_i(rdata), .addr_o(addr),
		.rd_o(rd), .wr_o(wr), .wdata_o(wdata));
	always #25 clk = ~clk;
	// ****************************************
	// helpers
	// ****************************************
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk
	task rchk(input logic [15:0] a, input logic [7:0] e);
		uife_cpu_model_i.rd(a, d);
		chk(d, e);
	endtask : rchk
	task wr_en(input logic [7:0] i, input logic [7:0] o, input logic [7:0] c);
		uife_cpu_model_i.wr(IN_EN_ADDR, i);
		uife_cpu_model_i.wr(OUT_EN_ADDR, o);
		uife_cpu_model_i.wr(COM_EN_ADDR, c);
	endtask : wr_en
	task pulse(input logic [5:0] i, input logic [5:1] o, input logic [3:0] b);
		@(posedge clk);
		in_evt <= i;
		out_evt <= o;
		bus_evt <= b;
		@(posedge clk);
		in_evt <= '0;
		out_evt <= '0;
		bus_evt <= '0;
	endtask : pulse
	// irq is registered from the flags, so look two edges after the cause
	task irq_chk(input logic e);
		repeat (2) @(posedge clk);
		#1 chk({7'h00, irq}, {7'h00, e});
	endtask : irq_chk
	// ****************************************
	// scenarios
	// ****************************************
	task t_reset();
		rchk(IN_EN_ADDR, 8'h3f);
		rchk(OUT_EN_ADDR, 8'h3f);
		rchk(COM_EN_ADDR, 8'h06);
		rchk(IN_FLAGS_ADDR, 8'h00);
		rchk(OUT_FLAGS_ADDR, 8'h00);
		rchk(COM_FLAGS_ADDR, 8'h00);
		rchk(16'h6203, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask : t_reset
	task t_busrst();
		wr_en(8'h00, 8'h00, 8'h09);
		pulse(6'h00, 5'h00, 4'h4);
		irq_chk(1'b1);
		rchk(IN_EN_ADDR, 8'h3f);
		rchk(OUT_EN_ADDR, 8'h3f);
		rchk(COM_EN_ADDR, 8'h0f);
		rchk(COM_FLAGS_ADDR, 8'h04);
		irq_chk(1'b0);
	endtask : t_busrst
	task t_flags();
		wr_en(8'h00, 8'h00, 8'h00);
		rchk(OUT_EN_ADDR, 8'h01);
		pulse(6'h3f, 5'h1f, 4'hb);
		irq_chk(1'b0);
		uife_cpu_model_i.wr(OUT_EN_ADDR, 8'h20);
		irq_chk(1'b1);
		rchk(OUT_FLAGS_ADDR, 8'h3e);
		irq_chk(1'b0);
		rchk(IN_FLAGS_ADDR, 8'h3f);
		rchk(COM_FLAGS_ADDR, 8'h0b);
		rchk(IN_FLAGS_ADDR, 8'h00);
		rchk(OUT_FLAGS_ADDR, 8'h00);
		rchk(COM_FLAGS_ADDR, 8'h00);
	endtask : t_flags
	// frame flag alone with its enable off, then the common and in masks opened in turn
	task t_mask();
		pulse(6'h00, 5'h00, 4'h8);
		irq_chk(1'b0);
		uife_cpu_model_i.wr(COM_EN_ADDR, 8'h08);
		irq_chk(1'b1);
		rchk(COM_FLAGS_ADDR, 8'h08);
		irq_chk(1'b0);
		uife_cpu_model_i.wr(IN_EN_ADDR, 8'h02);
		pulse(6'h02, 5'h00, 4'h0);
		irq_chk(1'b1);
		rchk(IN_FLAGS_ADDR, 8'h02);
		irq_chk(1'b0);
	endtask : t_mask
	task t_collide();
		pulse(6'h01, 5'h00, 4'h0);
		fork
			uife_cpu_model_i.rd(IN_FLAGS_ADDR, d);
			pulse(6'h02, 5'h00, 4'h0);
		join
		chk(d, 8'h01);
		rchk(IN_FLAGS_ADDR, 8'h02);
	endtask : t_collide
	// mid-run reset with flags set and masks changed
	task t_rerst();
		wr_en(8'h00, 8'h00, 8'h00);
		pulse(6'h3f, 5'h1f, 4'hb);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
	endtask : t_rerst
	task stop_test();
		$display("errors=%0d checks=%0d", err_total, n_checks);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		in_evt = '0;
		out_evt = '0;
		bus_evt = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_busrst();
		t_flags();
		t_mask();
		t_collide();
		t_rerst();
		stop_test();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		#100000;
		err_total++;
		stop_test();
	end
endmodule : tb_usb_interrupt_flags_enables

// *** test/uife_cpu_model.sv ***
// Purpose: cpu side model that reads and writes the flag and enable registers
// Assumes: one byte per access, strobes held for exactly one cycle
// Notes:   a read leaves one idle cycle before the next access
`timescale 1ns/1ps
module uife_cpu_model
	import uife_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic [7:0]  rdata_i,
	output logic      [15:0] addr_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [7:0]  wdata_o
);
	initial begin
		addr_o = 16'h0000;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end
	task rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask : rd
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		wr_o <= 1'b1;
		// reserved bits 7:6 of the in and out enables always go out as zero
		wdata_o <= (a == IN_EN_ADDR || a == OUT_EN_ADDR) ? (d & 8'h3f) : d;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
	endtask : wr
endmodule : uife_cpu_model
